// ### hdl/bbcd_defines.vh
// bbcd_defines.vh: opcode encodings, cycle counts and field positions
// for the branch/bit/control/jump decoder; definitions only
`ifndef BBCD_DEFINES_VH
`define BBCD_DEFINES_VH
// low-nibble opcode classes
`define BBCD_LO_BNZ      4'h0
`define BBCD_LO_CALL     4'h1
`define BBCD_LO_BNC      4'h2
`define BBCD_LO_BTST     4'h3
`define BBCD_LO_BZ       4'h4
`define BBCD_LO_BC       4'h6
`define BBCD_LO_JP       4'h9
`define BBCD_LO_BITOP    4'hb
`define BBCD_LO_CTRL     4'hd
// full opcodes of the inherent control group (low nibble d, except NOP at 04)
`define BBCD_OP_NOP      8'h04
`define BBCD_OP_INTERRUPT_RETURN     8'h4d
`define BBCD_OP_RET      8'hcd
`define BBCD_OP_STOP     8'h6d
`define BBCD_OP_WAIT     8'hed
// cycle counts
`define BBCD_CYC_REL     3'd2
`define BBCD_CYC_BTST    3'd5
`define BBCD_CYC_BITOP   3'd4
`define BBCD_CYC_CTRL    3'd2
`define BBCD_CYC_EXT     3'd4
// field positions
`define BBCD_BIT_LSB     5
`define BBCD_BTST_POL    4
`define BBCD_BITOP_SET   4
`define BBCD_REL_SIGN    4
`define BBCD_PC_RESET    12'h000
`endif

// ### hdl/bbcd_decoder.v
// bbcd_decoder.v: executes branch, bit, control and jump/call opcodes
// assumes program memory answers fetch address in the same cycle and a
// single-cycle data-space read/write port; other opcodes flagged illegal
`timescale 1ns/10ps
`include "bbcd_defines.vh"

// Overview of operation
// [RULE1] relative branches test carry or zero, 2 cycles
// [RULE2] short displacement is 5-bit signed from branch
// [RULE3] span -15..+16; else next instruction; code reaches odd offsets -15..+15 only (field bit 3 is 0)
// [RULE4] bit-test branch: 3 bytes, 5 cycles
// [RULE5] tested bit copied into carry always
// [RULE6] third byte is 8-bit signed displacement
// [RULE7] second byte addresses tested data byte
// [RULE8] 3-bit opcode field picks the bit
// [RULE9] bit ops reach any data byte
// [RULE10] bit set: 2 bytes, 4 cycles, flags kept
// [RULE11] bit clear: 2 bytes, 4 cycles
// [RULE12] control ops 1 byte 2 cycles; interrupt return flags
// [RULE13] stop becomes wait when watchdog selected
// [RULE14] jump/call: 2 bytes, 4 cycles, 12-bit target
// [RULE15] decode by low nibble; unused opcodes illegal
module bbcd_decoder #(
  parameter PC_W = 12                     // program address width
) (
  input  wire            clock,           // core clock
  input  wire            rst,             // sync reset, high
  input  wire [7:0]      prog_data,       // byte at prog_addr
  input  wire [7:0]      data_rdata,      // data-space read byte
  input  wire            watchdog_sel,    // watchdog function selected
  input  wire [PC_W-1:0] stack_top,       // return address from stack
  input  wire            saved_zero,      // flags restored on interrupt return
  input  wire            saved_carry,     // flags restored on interrupt return
  output reg  [PC_W-1:0] prog_addr,       // program fetch address
  output reg  [7:0]      data_addr,       // data-space address
  output reg  [7:0]      data_wdata,      // data-space write byte
  output reg             data_we,         // data-space write strobe
  output reg             zero_flag,       // zero flag
  output reg             carry_flag,      // carry flag
  output reg             push_pulse,      // push return address (call)
  output reg  [PC_W-1:0] push_addr,       // address pushed
  output reg             pop_pulse,       // pop stack (returns)
  output reg             wait_pulse,      // enter wait mode
  output reg             stop_pulse,      // enter stop mode
  output reg             illegal_pulse,   // unused opcode seen
  output reg             instr_done       // last cycle of an instruction
);
  localparam S_FETCH = 2'd0;
  localparam S_EXEC  = 2'd1;

  reg [1:0]      state_reg;
  reg [2:0]      cnt_reg;
  reg [7:0]      op_reg;
  reg [PC_W-1:0] pc_reg;
  reg            bit_val_reg;

  wire [3:0] lo      = op_reg[3:0];
  wire [2:0] bit_sel = op_reg[`BBCD_BIT_LSB +: 3]; // RULE8
  // opcode class decode by low nibble
  wire is_rel   = (lo == `BBCD_LO_BNZ) || (lo == `BBCD_LO_BNC) ||
                  (lo == `BBCD_LO_BZ)  || (lo == `BBCD_LO_BC);     // RULE1
  wire is_btst  = (lo == `BBCD_LO_BTST);                            // RULE4
  wire is_bitop = (lo == `BBCD_LO_BITOP);                           // RULE9
  wire is_ext   = (lo == `BBCD_LO_CALL) || (lo == `BBCD_LO_JP);     // RULE14
  wire is_call  = (lo == `BBCD_LO_CALL);
  wire is_ctrl  = (lo == `BBCD_LO_CTRL);                            // RULE12
  wire is_ret   = (op_reg == `BBCD_OP_RET) || (op_reg == `BBCD_OP_INTERRUPT_RETURN);
  // exec phase strobes; cnt_reg counts exec cycles from 1
  wire fetch_b2   = (cnt_reg == 3'd1) && (is_btst || is_bitop);
  // data byte settles one cycle after its address is registered
  wire modify_cyc = (cnt_reg == 3'd2) && is_bitop;
  wire sample_cyc = (cnt_reg == 3'd2) && is_btst;
  wire bit_hit    = (bit_val_reg == op_reg[`BBCD_BTST_POL]);
  // fall-through and return addresses, kept at pc width
  wire [PC_W-1:0] seq_next  = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] btst_fall = pc_reg + {{(PC_W-2){1'b0}}, 2'd3};
  wire [PC_W-1:0] call_ret  = pc_reg + {{(PC_W-2){1'b0}}, 2'd2};
  wire [PC_W-1:0] ext_tgt   = {op_reg[7:4], prog_data};
  // short branch: 5-bit signed field built from bits 7:3
  wire [4:0]      short_disp = op_reg[7:3];                                           // RULE2
  wire [PC_W-1:0] short_tgt  = pc_reg + {{(PC_W-5){short_disp[4]}}, short_disp} + 1'b1; // RULE3
  wire [PC_W-1:0] long_tgt   = pc_reg + {{(PC_W-8){prog_data[7]}}, prog_data} + 1'b1;   // RULE6
  wire [7:0]      bit_mask   = 8'h01 << bit_sel;
  wire            cur_bit    = |(data_rdata & bit_mask);
  reg  [2:0]      cycles;

  always @* begin
    case (lo)
      `BBCD_LO_BNZ, `BBCD_LO_BNC, `BBCD_LO_BZ, `BBCD_LO_BC: cycles = `BBCD_CYC_REL; // RULE1
      `BBCD_LO_BTST:  cycles = `BBCD_CYC_BTST;  // RULE4
      `BBCD_LO_BITOP: cycles = `BBCD_CYC_BITOP; // RULE10 RULE11
      `BBCD_LO_CTRL:  cycles = `BBCD_CYC_CTRL;  // RULE12
      `BBCD_LO_CALL, `BBCD_LO_JP: cycles = `BBCD_CYC_EXT; // RULE14
      default:        cycles = 3'd1;
    endcase
  end

  reg take;
  always @* begin
    case (lo)
      `BBCD_LO_BC:  take = carry_flag;  // RULE1
      `BBCD_LO_BNC: take = ~carry_flag;
      `BBCD_LO_BZ:  take = zero_flag;
      `BBCD_LO_BNZ: take = ~zero_flag;
      default:      take = 1'b0;
    endcase
  end

  // fetch address after the last exec cycle; second or third byte
  // is still on the bus then, so no extra holding register is needed
  reg [PC_W-1:0] end_addr;
  always @* begin
    case (lo)
      `BBCD_LO_BNZ, `BBCD_LO_BNC, `BBCD_LO_BZ, `BBCD_LO_BC:
        end_addr = take ? short_tgt : seq_next;     // RULE3
      `BBCD_LO_BTST:
        end_addr = bit_hit ? long_tgt : btst_fall;  // RULE6
      `BBCD_LO_CALL, `BBCD_LO_JP:
        end_addr = ext_tgt;                         // RULE14
      `BBCD_LO_CTRL:
        end_addr = is_ret ? stack_top : prog_addr;
      default:
        end_addr = prog_addr;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_reg     <= S_FETCH;
      cnt_reg       <= 3'd0;
      op_reg        <= 8'h00;
      pc_reg        <= `BBCD_PC_RESET;
      bit_val_reg   <= 1'b0;
      prog_addr     <= `BBCD_PC_RESET;
      data_addr     <= 8'h00;
      data_wdata    <= 8'h00;
      data_we       <= 1'b0;
      zero_flag     <= 1'b0;
      carry_flag    <= 1'b0;
      push_pulse    <= 1'b0;
      push_addr     <= {PC_W{1'b0}};
      pop_pulse     <= 1'b0;
      wait_pulse    <= 1'b0;
      stop_pulse    <= 1'b0;
      illegal_pulse <= 1'b0;
      instr_done    <= 1'b0;
    end else begin
      data_we       <= 1'b0;
      push_pulse    <= 1'b0;
      pop_pulse     <= 1'b0;
      wait_pulse    <= 1'b0;
      stop_pulse    <= 1'b0;
      illegal_pulse <= 1'b0;
      instr_done    <= 1'b0;
      case (state_reg)
        S_FETCH: begin
          op_reg    <= prog_data;
          pc_reg    <= prog_addr;
          prog_addr <= prog_addr + 1'b1;
          cnt_reg   <= 3'd1;
          state_reg <= S_EXEC;
        end
        S_EXEC: begin
          cnt_reg <= cnt_reg + 3'd1;
          // second byte is on the bus in exec cycle 1
          if (fetch_b2) begin
            data_addr <= prog_data;       // RULE7 RULE9
            prog_addr <= prog_addr + 1'b1;
          end
          if (modify_cyc) begin
            data_wdata <= op_reg[`BBCD_BITOP_SET] ? (data_rdata | bit_mask)   // RULE10
                                                  : (data_rdata & ~bit_mask); // RULE11
            data_we    <= 1'b1;
          end
          if (sample_cyc) begin
            bit_val_reg <= cur_bit;
            carry_flag  <= cur_bit;       // RULE5
          end
          if (cnt_reg == cycles) begin
            instr_done <= 1'b1;
            state_reg  <= S_FETCH;
            // zero flag left alone by every branch form
            prog_addr  <= end_addr;       // RULE4
            if (is_call) begin
              push_pulse <= 1'b1;
              push_addr  <= call_ret;
            end
            if (is_ctrl) begin
              case (op_reg)
                `BBCD_OP_RET: begin
                  pop_pulse <= 1'b1;
                end
                `BBCD_OP_INTERRUPT_RETURN: begin
                  pop_pulse  <= 1'b1;
                  zero_flag  <= saved_zero;  // RULE12
                  carry_flag <= saved_carry;
                end
                // watchdog forbids stop: wait keeps the dog serviced
                `BBCD_OP_STOP: begin
                  if (watchdog_sel) wait_pulse <= 1'b1; // RULE13
                  else stop_pulse <= 1'b1;
                end
                `BBCD_OP_WAIT: wait_pulse <= 1'b1;
                default: illegal_pulse <= 1'b1;
              endcase
            end else if (!(is_rel || is_btst || is_bitop || is_ext)) begin
              illegal_pulse <= 1'b1;      // RULE15
            end
          end
        end
        default: state_reg <= S_FETCH;
      endcase
    end
  end
endmodule

// ### testbench/bbcd_mem_model.sv
// bbcd_mem_model.sv: program memory and data space beside the decoder
// assumes the bench preloads prog and dmem through the hierarchy
`timescale 1ns/10ps
module bbcd_mem_model (
  input  wire logic        clock,      // core clock
  input  wire logic [11:0] prog_addr,  // fetch address
  output logic      [7:0]  prog_data,  // opcode byte
  input  wire logic [7:0]  data_addr,  // data address
  input  wire logic [7:0]  data_wdata, // write byte
  input  wire logic        data_we,    // write strobe
  output logic      [7:0]  data_rdata  // read byte
);
  logic [7:0] prog [0:4095];
  logic [7:0] dmem [0:255];
  assign prog_data  = prog[prog_addr];
  assign data_rdata = dmem[data_addr];
  always @(posedge clock) begin
    if (data_we)
      dmem[data_addr] <= data_wdata;
  end
endmodule

// ### testbench/bbcd_decoder_chk.sv
// bbcd_decoder_chk.sv: port assertions for the decoder
// assumes bench holds saved flags and watchdog select over each instruction
`timescale 1ns/10ps
module bbcd_chk (
  input wire logic clock,         // core clock
  input wire logic rst,           // sync reset
  input wire logic watchdog_sel,  // watchdog selected
  input wire logic saved_zero,    // restored zero
  input wire logic instr_done,    // instruction end
  input wire logic data_we,       // write strobe
  input wire logic zero_flag,     // zero flag
  input wire logic push_pulse,    // call push
  input wire logic stop_pulse,    // stop entry
  input wire logic wait_pulse,    // wait entry
  input wire logic illegal_pulse  // unused opcode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_done_pulse: assert property (instr_done |=> !instr_done) else $error("done too long");
  a_we_pulse: assert property (data_we |=> !data_we [*3]) else $error("write repeated");
  a_we_done: assert property (data_we |-> ##[1:3] instr_done) else $error("bit op late");
  a_stop_masked: assert property (stop_pulse |-> !watchdog_sel) else $error("stop under watchdog");
  a_halt_excl: assert property (!(stop_pulse && wait_pulse)) else $error("stop and wait");
  a_zero_src: assert property ($changed(zero_flag) |-> zero_flag == saved_zero) else $error("zero moved");
  a_push_done: assert property (push_pulse |-> instr_done) else $error("call push off end");
  a_illegal_done: assert property (illegal_pulse |-> ##[0:2] instr_done) else $error("illegal hung");
  cover property (stop_pulse);
  cover property (wait_pulse && watchdog_sel);
  cover property (data_we);
endmodule
bind bbcd_decoder bbcd_chk chk_inst (.clock(clock), .rst(rst), .watchdog_sel(watchdog_sel),
  .saved_zero(saved_zero), .instr_done(instr_done), .data_we(data_we), .zero_flag(zero_flag),
  .push_pulse(push_pulse), .stop_pulse(stop_pulse), .wait_pulse(wait_pulse), .illegal_pulse(illegal_pulse));

// ### testbench/branch_bit_control_decoder_tb.sv
// branch_bit_control_decoder_tb.sv: random program run against a bench model
// assumes pc only moves forward so placed bytes are never reused
`timescale 1ns/10ps
`include "bbcd_defines.vh"
module branch_bit_control_decoder_tb;
  logic clock = 0, rst = 1, watchdog_sel = 0, saved_zero = 0, saved_carry = 0;
  logic [11:0] stack_top = 0, nx, tg, cap, e_pc [0:63], e_st [0:63], e_val [0:63];
  wire [11:0] prog_addr, push_addr;
  wire [7:0] prog_data, data_rdata, data_addr, data_wdata;
  wire data_we, zero_flag, carry_flag, push_pulse, pop_pulse, wait_pulse, stop_pulse, illegal_pulse, instr_done;
  integer seed = 32'h11422fad, miscompares = 0, n_checks = 0, k = 0, cnt = 0, tcnt = 0, i, a, z, c;
  reg [7:0] dm [0:255], op, da, dd;
  reg [5:0] e_ev [0:63], seen;
  reg [3:0] e_cy [0:63];
  reg [2:0] e_in [0:63];
  reg e_z [0:63], e_c [0:63];
  reg [31:0] r;
  always #10 clock = ~clock;
  bbcd_decoder bbcd_decoder_inst (.clock(clock), .rst(rst), .prog_data(prog_data), .data_rdata(data_rdata),
    .watchdog_sel(watchdog_sel), .stack_top(stack_top), .saved_zero(saved_zero), .saved_carry(saved_carry),
    .prog_addr(prog_addr), .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .push_pulse(push_pulse), .push_addr(push_addr),
    .pop_pulse(pop_pulse), .wait_pulse(wait_pulse), .stop_pulse(stop_pulse), .illegal_pulse(illegal_pulse),
    .instr_done(instr_done));
  bbcd_mem_model bbcd_mem_model_inst (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata));
  task pm(input integer ad, input [7:0] v); bbcd_mem_model_inst.prog[ad] = v; endtask
  task chk(input string nm, input [11:0] e, input [11:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("test random_program done");
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    a = 0; z = 0; c = 0;
    for (i = 0; i < 256; i = i + 1) begin
      dm[i] = $random(seed);
      bbcd_mem_model_inst.dmem[i] = dm[i];
    end
    for (i = 0; i < 60; i = i + 1) begin
      r = $random(seed); e_in[i] = r[6:4]; e_st[i] = a + 1 + r[11:8]; e_ev[i] = 0; e_cy[i] = 2; e_val[i] = 0;
      nx = a + 1; da = r[31:24]; dd = 3 + r[22:18]; tg = a + 2 + r[21:16];
      case (r[3:0] % 9)
        0: begin op = {1'b0, r[15:13], 1'b0, r[17:16], 1'b0}; if (r[17] ? (r[16] ? c : z) : (r[16] ? !c : !z)) nx = a + op[7:3] + 1; end
        1: begin op = {r[15:13], r[16], 4'h3}; c = dm[da][r[15:13]]; e_cy[i] = 5; nx = (c == r[16]) ? a + dd + 1 : a + 3; end
        2: begin op = {r[15:13], r[16], 4'hb}; dm[da][r[15:13]] = r[16]; e_val[i] = dm[da]; e_ev[i] = 1; e_cy[i] = 4; nx = a + 2; end
        3: begin op = {tg[11:8], r[12] ? 4'h1 : 4'h9}; da = tg[7:0]; e_val[i] = a + 2; e_ev[i] = {r[12], 1'b0}; e_cy[i] = 4; nx = tg; end
        4: begin op = `BBCD_OP_INTERRUPT_RETURN; z = r[5]; c = r[4]; e_ev[i] = 4; nx = e_st[i]; end
        5: begin op = `BBCD_OP_RET; e_ev[i] = 4; nx = e_st[i]; end
        6: begin op = `BBCD_OP_STOP; e_ev[i] = r[6] ? 8 : 16; end
        7: begin op = `BBCD_OP_WAIT; e_ev[i] = 8; end
        default: begin op = 8'h05; e_ev[i] = 32; e_cy[i] = 0; end
      endcase
      pm(a, op); pm(a + 1, da); pm(a + 2, dd);
      e_pc[i] = nx; e_z[i] = z; e_c[i] = c; a = nx;
    end
    {watchdog_sel, saved_zero, saved_carry} = e_in[0];
    stack_top = e_st[0];
    repeat (20) @(posedge clock);
    rst <= 0;
    wait (k == 60);
    end_sim;
  end
  always @(posedge clock) begin
    tcnt = tcnt + 1;
    if (tcnt == 3000) begin
      miscompares = miscompares + 1;
      end_sim;
    end else if (rst) begin
      cnt = -1;
      seen = 0;
    end else begin
      cnt = cnt + 1;
      seen = seen | {illegal_pulse, stop_pulse, wait_pulse, pop_pulse, push_pulse, data_we};
      if (data_we) cap = data_wdata;
      if (push_pulse) cap = push_addr;
      if (instr_done && k < 60) begin
        chk("next_pc", e_pc[k], prog_addr);
        chk("flags", {e_z[k], e_c[k]}, {zero_flag, carry_flag});
        chk("events", e_ev[k], seen);
        if (e_cy[k] != 0) chk("cycles", e_cy[k] + 1, cnt);
        if (e_ev[k][1:0] != 0) chk("value", e_val[k], cap);
        k = k + 1; cnt = 0; seen = 0;
        {watchdog_sel, saved_zero, saved_carry} <= e_in[k];
        stack_top <= e_st[k];
      end
    end
  end
endmodule
